// File: rtl/sleep_reset_regs.vh
// Register offsets, field positions, encodings and timing constants
`ifndef SLEEP_RESET_REGS_VH
`define SLEEP_RESET_REGS_VH
`define IO_SLEEP_CTRL 6'h35
`define DATA_SPACE_BASE 8'h20
`define DATA_SLEEP_CTRL 8'h55
`define IO_CTRL_STATUS 6'h34
`define SLEEP_CTRL_RESET 8'h00
`define CTRL_STATUS_RESET 8'h00
`define SLEEP_ENABLE_POS 7
`define MODE_HI 6
`define MODE_LO 4
`define TEST_PORT_DISABLE_POS 7
`define MODE_IDLE 3'h0
`define MODE_NOISE 3'h1
`define MODE_PDOWN 3'h2
`define MODE_PSAVE 3'h3
`define MODE_RSVD4 3'h4
`define MODE_RSVD5 3'h5
`define MODE_STANDBY 3'h6
`define MODE_EXT_STANDBY 3'h7
`define WAKE_STALL_CYCLES 4'h4
`define TIMEOUT_SHORT 20'h00006
`define TIMEOUT_MID 20'h00400
`define TIMEOUT_LONG 20'h10000
`define EXT_RESET_MIN_NS 1500
`define CLK_PERIOD_NS 50
`define EXT_RESET_MIN_CYC ((`EXT_RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// File: rtl/reset_stretch.v
// Delay counter that stretches internal reset after all sources go quiet
`timescale 1ns/1ps
module reset_stretch
#(
   parameter CNT_W = 20
)
(
   sys_clk,
   any_reset_n,
   timeout_cycles,
   core_reset_n
);
   input wire sys_clk;
   input wire any_reset_n;
   input wire [CNT_W-1:0] timeout_cycles;
   output reg core_reset_n;

   reg [CNT_W-1:0] count_q;

   // Counter is cleared asynchronously by any source; counts after release
   always @(posedge sys_clk or negedge any_reset_n)
   begin
      if (!any_reset_n)
      begin
         count_q <= {CNT_W{1'b0}};
         core_reset_n <= 1'b0;
      end
      else if (count_q >= timeout_cycles)
      begin
         core_reset_n <= 1'b1;
      end
      else
      begin
         count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end
endmodule

// File: rtl/sleep_and_reset_control.v
// Sleep mode selection, analog gating and reset merging
`timescale 1ns/1ps
`include "sleep_reset_regs.vh"
module sleep_and_reset_control
#(
   parameter CNT_W = 20,
   parameter TIMEOUT_SHORT = `TIMEOUT_SHORT,
   parameter TIMEOUT_MID = `TIMEOUT_MID,
   parameter TIMEOUT_LONG = `TIMEOUT_LONG
)
(
   sys_clk,
   reset_n,
   io_addr,
   io_wdata,
   io_write,
   data_space,
   io_rdata,
   sleep_instr,
   wake_irq,
   clock_select_fuses,
   ext_crystal_sel,
   brownout_enable_fuse,
   debug_enable_fuse,
   test_port_fuse,
   power_on_low,
   ext_reset_pin_n,
   watchdog_enable,
   watchdog_expired,
   brownout_low,
   test_reset_reg,
   tap_shifting,
   tdo_data,
   adc_enable,
   comparator_enable,
   comparator_uses_ref,
   sleeping,
   active_mode,
   cpu_stall,
   adc_power,
   adc_extended_conv,
   comparator_power,
   ref_enable,
   brownout_active,
   watchdog_run,
   input_buf_enable,
   main_clock_keep,
   test_port_enable,
   tdo_out,
   tdo_oe,
   port_reset_n,
   core_reset_n,
   fetch_vector
);
   input wire sys_clk;
   input wire reset_n;
   input wire [7:0] io_addr;
   input wire [7:0] io_wdata;
   input wire io_write;
   input wire data_space;
   output reg [7:0] io_rdata;
   input wire sleep_instr;
   input wire wake_irq;
   input wire [3:0] clock_select_fuses;
   input wire ext_crystal_sel;
   input wire brownout_enable_fuse;
   input wire debug_enable_fuse;
   input wire test_port_fuse;
   input wire power_on_low;
   input wire ext_reset_pin_n;
   input wire watchdog_enable;
   input wire watchdog_expired;
   input wire brownout_low;
   input wire test_reset_reg;
   input wire tap_shifting;
   input wire tdo_data;
   input wire adc_enable;
   input wire comparator_enable;
   input wire comparator_uses_ref;
   output reg sleeping;
   output reg [2:0] active_mode;
   output wire cpu_stall;
   output wire adc_power;
   output reg adc_extended_conv;
   output wire comparator_power;
   output wire ref_enable;
   output wire brownout_active;
   output wire watchdog_run;
   output wire input_buf_enable;
   output wire main_clock_keep;
   output wire test_port_enable;
   output reg tdo_out;
   output wire tdo_oe;
   output wire port_reset_n;
   output wire core_reset_n;
   output reg fetch_vector;

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   reg [6:0] sync1_q;
   reg [6:0] sync2_q;
   wire bo_low_s = sync2_q[0];
   wire pin_n_s = sync2_q[1];
   wire wd_exp_s = sync2_q[2];
   wire tr_s = sync2_q[3];
   wire adc_en_s = sync2_q[4];
   wire irq_s = sync2_q[5];
   wire shift_s = sync2_q[6];

   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sync1_q <= 7'h00;
         sync2_q <= 7'h02;
      end
      else
      begin
         sync1_q <= {tap_shifting, wake_irq, adc_enable, test_reset_reg,
                     watchdog_expired, ext_reset_pin_n, brownout_low};
         sync2_q <= sync1_q;
      end
   end

   // ----------------------------------------------------------------
   // Reset merging
   // ----------------------------------------------------------------
   // Pin filter: low must persist for the minimum width
   reg [7:0] pin_low_cnt_q;
   reg ext_rst_q;
   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pin_low_cnt_q <= 8'h00;
         ext_rst_q <= 1'b0;
      end
      else if (pin_n_s)
      begin
         pin_low_cnt_q <= 8'h00;
         ext_rst_q <= 1'b0;
      end
      else if ({24'h000000, pin_low_cnt_q} >= `EXT_RESET_MIN_CYC)
         ext_rst_q <= 1'b1;
      else
         pin_low_cnt_q <= pin_low_cnt_q + 8'h01;
   end

   wire wd_rst = watchdog_enable & wd_exp_s;
   wire bo_rst = brownout_enable_fuse & bo_low_s;
   wire any_src = power_on_low | ext_rst_q | wd_rst | bo_rst | tr_s;
   // Power-on and base reset reach ports with no clock needed
   assign port_reset_n = reset_n & ~power_on_low & ~any_src;

   reg [CNT_W-1:0] timeout_sel;
   always @*
   begin
      case (clock_select_fuses[3:2])
         2'h0: timeout_sel = TIMEOUT_SHORT[CNT_W-1:0];
         2'h1: timeout_sel = TIMEOUT_MID[CNT_W-1:0];
         default: timeout_sel = TIMEOUT_LONG[CNT_W-1:0];
      endcase
   end

   reset_stretch #(.CNT_W(CNT_W)) u_stretch
   (
      .sys_clk(sys_clk),
      .any_reset_n(port_reset_n),
      .timeout_cycles(timeout_sel),
      .core_reset_n(core_reset_n)
   );

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   function hit;
      input [7:0] a;
      input ds;
      input [5:0] io_off;
      begin
         hit = ds ? (a == ({2'b00, io_off} + `DATA_SPACE_BASE))
                  : (a == {2'b00, io_off});
      end
   endfunction

   reg [7:0] sleep_control_reg_q;
   reg [7:0] control_status_reg_q;
   wire scr_hit = hit(io_addr, data_space, `IO_SLEEP_CTRL);
   wire csr_hit = hit(io_addr, data_space, `IO_CTRL_STATUS);

   always @(posedge sys_clk or negedge core_reset_n)
   begin
      if (!core_reset_n)
      begin
         sleep_control_reg_q <= `SLEEP_CTRL_RESET;
         control_status_reg_q <= `CTRL_STATUS_RESET;
      end
      else if (io_write)
      begin
         if (scr_hit)
            sleep_control_reg_q <= {io_wdata[7:4], 4'h0};
         if (csr_hit)
            control_status_reg_q <= {io_wdata[7], 7'h00};
      end
   end

   always @*
   begin
      if (scr_hit)
         io_rdata = sleep_control_reg_q;
      else if (csr_hit)
         io_rdata = control_status_reg_q;
      else
         io_rdata = 8'h00;
   end

   wire sleep_enable_bit = sleep_control_reg_q[`SLEEP_ENABLE_POS];
   wire [2:0] sleep_mode_field =
      sleep_control_reg_q[`MODE_HI:`MODE_LO];
   wire test_port_disable_bit =
      control_status_reg_q[`TEST_PORT_DISABLE_POS];

   // ----------------------------------------------------------------
   // Sleep sequencer
   // ----------------------------------------------------------------
   localparam ST_RUN = 2'b00;
   localparam ST_SLEEP = 2'b01;
   localparam ST_STALL = 2'b10;

   function mode_ok;
      input [2:0] m;
      input xtal;
      begin
         case (m)
            `MODE_RSVD4, `MODE_RSVD5: mode_ok = 1'b0;
            `MODE_STANDBY, `MODE_EXT_STANDBY: mode_ok = xtal;
            default: mode_ok = 1'b1;
         endcase
      end
   endfunction

   reg [1:0] state_q;
   reg [3:0] stall_q;
   always @(posedge sys_clk or negedge core_reset_n)
   begin
      if (!core_reset_n)
      begin
         state_q <= ST_RUN;
         stall_q <= 4'h0;
         sleeping <= 1'b0;
         active_mode <= `MODE_IDLE;
         fetch_vector <= 1'b1;
      end
      else
      begin
         fetch_vector <= 1'b0;
         case (state_q)
            ST_RUN:
               if (sleep_instr && sleep_enable_bit &&
                   mode_ok(sleep_mode_field, ext_crystal_sel))
               begin
                  state_q <= ST_SLEEP;
                  sleeping <= 1'b1;
                  active_mode <= sleep_mode_field;
               end
            ST_SLEEP:
               if (irq_s)
               begin
                  state_q <= ST_STALL;
                  sleeping <= 1'b0;
                  stall_q <= `WAKE_STALL_CYCLES;
               end
            ST_STALL:
               if (stall_q == 4'h1)
                  state_q <= ST_RUN;
               else
                  stall_q <= stall_q - 4'h1;
            default:
               state_q <= ST_RUN;
         endcase
      end
   end
   assign cpu_stall = (state_q == ST_STALL);

   // ----------------------------------------------------------------
   // Analog and clock gating
   // ----------------------------------------------------------------
   wire deep = sleeping && (active_mode != `MODE_IDLE) &&
               (active_mode != `MODE_NOISE);
   assign adc_power = adc_en_s;
   assign comparator_power = comparator_enable & ~deep;
   assign ref_enable = brownout_enable_fuse | adc_en_s |
                       (comparator_enable & comparator_uses_ref);
   assign brownout_active = brownout_enable_fuse;
   assign watchdog_run = watchdog_enable;
   // Wake-up pins keep their buffers outside this gate
   assign input_buf_enable = ~deep;
   assign main_clock_keep = sleeping & debug_enable_fuse &
      ((active_mode == `MODE_PDOWN) | (active_mode == `MODE_PSAVE));

   reg adc_en_prev_q;
   always @(posedge sys_clk or negedge core_reset_n)
   begin
      if (!core_reset_n)
      begin
         adc_en_prev_q <= 1'b0;
         adc_extended_conv <= 1'b1;
      end
      else
      begin
         adc_en_prev_q <= adc_en_s;
         if (!adc_en_s)
            adc_extended_conv <= 1'b1;
         else if (adc_en_prev_q)
            adc_extended_conv <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Test port
   // ----------------------------------------------------------------
   assign test_port_enable = test_port_fuse & ~test_port_disable_bit;
   assign tdo_oe = test_port_enable & shift_s;
   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         tdo_out <= 1'b0;
      else
         tdo_out <= tdo_data;
   end
endmodule

// File: verification/sleep_reset_checker_assertions.sv
// Concurrent checks on the sleep and reset control ports
`timescale 1ns/1ps
module sleep_reset_checker
(
   input wire sys_clk,
   input wire reset_n,
   input wire power_on_low,
   input wire port_reset_n,
   input wire ref_enable,
   input wire brownout_active,
   input wire brownout_enable_fuse,
   input wire adc_power,
   input wire comparator_enable,
   input wire comparator_uses_ref,
   input wire comparator_power,
   input wire sleeping,
   input wire [2:0] active_mode,
   input wire test_port_enable,
   input wire tap_shifting,
   input wire tdo_oe,
   input wire sleep_instr,
   input wire cpu_stall,
   input wire watchdog_enable,
   input wire watchdog_expired,
   input wire core_reset_n
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   a_port_async:
      assert property (power_on_low |-> !port_reset_n)
         else $error("port reset open");
   a_ref_need:
      assert property (ref_enable == (brownout_active || adc_power ||
         (comparator_enable && comparator_uses_ref)))
         else $error("reference enable wrong");
   a_bod_kept:
      assert property (brownout_enable_fuse |-> brownout_active)
         else $error("detector dropped");
   // Modes 2,3,6,7 all carry bit 1; reserved codes never become active
   a_cmp_deep:
      assert property (sleeping && active_mode[1] |-> !comparator_power)
         else $error("comparator on in deep sleep");
   // Three extra cycles cover the shift flag synchroniser
   a_tdo_float:
      assert property (test_port_enable && !(tap_shifting ||
         $past(tap_shifting) || $past(tap_shifting, 2) ||
         $past(tap_shifting, 3)) |-> !tdo_oe)
         else $error("test data out driven");
   a_sleep_cause:
      assert property ($rose(sleeping) |-> $past(sleep_instr))
         else $error("sleep without instruction");
   a_stall_len:
      assert property ($fell(sleeping) |-> cpu_stall [*4] ##1 !cpu_stall)
         else $error("wake stall length wrong");
   a_wd_reset:
      assert property ((watchdog_enable && watchdog_expired) [*4]
         |-> ##[0:6] !core_reset_n)
         else $error("watchdog reset missing");
endmodule

bind sleep_and_reset_control sleep_reset_checker chk (.sys_clk, .reset_n,
   .power_on_low, .port_reset_n, .ref_enable, .brownout_active,
   .brownout_enable_fuse, .adc_power, .comparator_enable,
   .comparator_uses_ref, .comparator_power, .sleeping, .active_mode,
   .test_port_enable, .tap_shifting, .tdo_oe, .sleep_instr, .cpu_stall,
   .watchdog_enable, .watchdog_expired, .core_reset_n);

// File: verification/core_model.sv
// Core model issuing register writes and sleep instructions
`timescale 1ns/1ps
`include "sleep_reset_regs.vh"
module core_model
(
   input wire sys_clk,
   output reg [7:0] io_addr = 8'h00,
   output reg [7:0] io_wdata = 8'h00,
   output reg io_write = 1'b0,
   output reg data_space = 1'b0,
   output reg sleep_instr = 1'b0
);
   task write_reg(input [7:0] a, input ds, input [7:0] d);
      begin
         @(posedge sys_clk);
         io_addr <= a;
         data_space <= ds;
         io_wdata <= d;
         io_write <= 1'b1;
         @(posedge sys_clk);
         io_write <= 1'b0;
         // Address held for readback; data no longer valid
         io_wdata <= ~d;
      end
   endtask
   task sleep_op;
      begin
         @(posedge sys_clk);
         sleep_instr <= 1'b1;
         @(posedge sys_clk);
         sleep_instr <= 1'b0;
      end
   endtask
endmodule

// File: verification/tb_sleep_and_reset_control.sv
// Self-checking bench for sleep and reset control
`timescale 1ns/1ps
`include "sleep_reset_regs.vh"
module tb_sleep_and_reset_control;
   reg sys_clk = 1'b0;
   reg reset_n = 1'b0;
   reg wake_irq = 1'b0;
   reg ext_crystal_sel = 1'b1;
   reg brownout_enable_fuse = 1'b0;
   reg watchdog_enable = 1'b0;
   reg adc_enable = 1'b0;
   reg comparator_enable = 1'b0;
   reg comparator_uses_ref = 1'b0;
   reg [3:0] clock_select_fuses = 4'h0;
   reg debug_enable_fuse = 1'b1;
   reg test_port_fuse = 1'b1;
   reg tap_shifting = 1'b0;
   reg tdo_data = 1'b1;
   reg [4:0] src = 5'h00;
   wire [7:0] io_addr, io_wdata, io_rdata;
   wire io_write, data_space, sleep_instr, sleeping, cpu_stall;
   wire comparator_power, port_reset_n, core_reset_n;
   wire adc_power, adc_extended_conv, watchdog_run, input_buf_enable;
   wire main_clock_keep, test_port_enable, tdo_out, tdo_oe, fetch_vector;
   wire [2:0] active_mode;
   wire power_on_low = src[0];
   wire ext_reset_pin_n = !src[1];
   wire watchdog_expired = src[2];
   wire brownout_low = src[3];
   wire test_reset_reg = src[4];
   // Row: crystal select, sleep expected, control byte
   logic [9:0] rows [11] = '{10'h20f, 10'h380, 10'h390, 10'h3a0, 10'h3b0,
      10'h2c0, 10'h2d0, 10'h3e0, 10'h3f0, 10'h0e0, 10'h0f0};
   logic [9:0] r;
   int n_mismatch = 0;
   int compares = 0;
   int cyc = 0;
   int n;
   int tmo = 4;
   bit seen;
   core_model core (.sys_clk, .io_addr, .io_wdata, .io_write, .data_space,
      .sleep_instr);
   sleep_and_reset_control #(.TIMEOUT_SHORT(4), .TIMEOUT_MID(8),
      .TIMEOUT_LONG(16)) i_sleep_and_reset_control (.sys_clk, .reset_n,
      .io_addr, .io_wdata, .io_write, .data_space, .io_rdata, .sleep_instr,
      .wake_irq, .clock_select_fuses, .ext_crystal_sel,
      .brownout_enable_fuse, .debug_enable_fuse, .test_port_fuse,
      .power_on_low, .ext_reset_pin_n, .watchdog_enable, .watchdog_expired,
      .brownout_low, .test_reset_reg, .tap_shifting, .tdo_data,
      .adc_enable, .comparator_enable, .comparator_uses_ref, .sleeping,
      .active_mode, .cpu_stall, .adc_power, .adc_extended_conv,
      .comparator_power, .ref_enable(), .brownout_active(), .watchdog_run,
      .input_buf_enable, .main_clock_keep, .test_port_enable,
      .tdo_out, .tdo_oe, .port_reset_n, .core_reset_n, .fetch_vector);
   always #25 sys_clk = ~sys_clk;
   task check(input [7:0] got, input [7:0] exp);
      begin
         compares++;
         if (got !== exp)
         begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time,
               got, exp);
         end
      end
   endtask
   task wrap_up;
      begin
         $display("compares %0d n_mismatch %0d", compares, n_mismatch);
         if (n_mismatch == 0 && compares > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   // Low count after release must show the stretch, sync included
   task rst_case(input int k, input int len, input bit exp);
      begin
         seen = 0;
         n = 0;
         src[k] <= 1'b1;
         #1 if (k == 0) check(port_reset_n, 0);
         repeat (len) @(posedge sys_clk) seen |= !core_reset_n;
         src[k] <= 1'b0;
         repeat (40)
         begin
            @(posedge sys_clk);
            seen |= !core_reset_n;
            n += !core_reset_n;
         end
         check(seen, exp);
         // Power-on adds one edge, synced sources up to four
         if (exp) check(n > tmo && n <= tmo + 4, 1);
         $display("reset case %0d done", k);
      end
   endtask
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_mismatch++;
         wrap_up;
      end
   end
   initial
   begin
      repeat (2) @(posedge sys_clk);
      reset_n <= 1'b1;
      while (core_reset_n !== 1'b1) @(posedge sys_clk);
      check(fetch_vector, 1);
      @(posedge sys_clk);
      check(fetch_vector, 0);
      adc_enable <= 1'b1;
      comparator_enable <= 1'b1;
      for (int i = 0; i < 11; i++)
      begin
         r = rows[i];
         ext_crystal_sel <= r[9];
         core.write_reg(i[0] ? `DATA_SLEEP_CTRL : {2'b00, `IO_SLEEP_CTRL},
            i[0], r[7:0]);
         @(posedge sys_clk);
         check(io_rdata, r[7:0] & 8'hf0);
         core.sleep_op;
         repeat (2) @(posedge sys_clk);
         check(sleeping, r[8]);
         if (r[8])
         begin
            check(active_mode, r[6:4]);
            check(comparator_power, !r[5]);
            check(input_buf_enable, !r[5]);
            check(main_clock_keep, r[5] & !r[6]);
            check(adc_power, 1);
            wake_irq <= 1'b1;
            for (n = 0; sleeping && n < 20; n++) @(posedge sys_clk);
            wake_irq <= 1'b0;
            for (n = 0; cpu_stall && n < 20; n++) @(posedge sys_clk);
            check(n, 4);
         end
         $display("row %0d done", i);
      end
      // Test port: shift-gated output enable, fuse and disable bit
      tap_shifting <= 1'b1;
      tdo_data <= 1'b0;
      repeat (4) @(posedge sys_clk);
      check(test_port_enable, 1);
      check(tdo_oe, 1);
      check(tdo_out, 0);
      test_port_fuse <= 1'b0;
      @(posedge sys_clk);
      check(test_port_enable, 0);
      check(tdo_oe, 0);
      test_port_fuse <= 1'b1;
      core.write_reg({2'b00, `IO_CTRL_STATUS}, 1'b0, 8'h80);
      @(posedge sys_clk);
      check(io_rdata, 8'h80);
      check(test_port_enable, 0);
      core.write_reg({2'b00, `IO_CTRL_STATUS}, 1'b0, 8'h00);
      tap_shifting <= 1'b0;
      tdo_data <= 1'b1;
      repeat (4) @(posedge sys_clk);
      check(test_port_enable, 1);
      check(tdo_oe, 0);
      check(tdo_out, 1);
      $display("test port case done");
      // Non-zero control value so the reset clear is visible
      core.write_reg({2'b00, `IO_SLEEP_CTRL}, 1'b0, 8'h90);
      @(posedge sys_clk);
      check(io_rdata, 8'h90);
      rst_case(0, 3, 1);
      check(io_rdata, 8'h00);
      rst_case(1, 5, 0);
      rst_case(1, 40, 1);
      rst_case(2, 4, 0);
      watchdog_enable <= 1'b1;
      rst_case(2, 4, 1);
      check(watchdog_run, 1);
      rst_case(3, 4, 0);
      brownout_enable_fuse <= 1'b1;
      rst_case(3, 4, 1);
      rst_case(4, 20, 1);
      clock_select_fuses <= 4'h4;
      tmo = 8;
      rst_case(0, 3, 1);
      clock_select_fuses <= 4'h8;
      tmo = 16;
      rst_case(0, 3, 1);
      comparator_uses_ref <= 1'b1;
      adc_enable <= 1'b0;
      repeat (6) @(posedge sys_clk);
      check(adc_power, 0);
      check(adc_extended_conv, 1);
      adc_enable <= 1'b1;
      repeat (3) @(posedge sys_clk);
      check(adc_extended_conv, 1);
      repeat (2) @(posedge sys_clk);
      check(adc_extended_conv, 0);
      $display("converter case done");
      wrap_up;
   end
endmodule
